// ### logic/cs_sense_counter.sv
// Capacitive sense channel select, control registers and counting timers
`timescale 1ns/100ps
`default_nettype none
// How it works
// - Eight sense pins, three-bit channel select
// - Channel change moves oscillator while enabled
// - Read-only bit shows oscillator source/sink phase
// - Two-bit field picks oscillator current range
// - Oscillator clocks byte or gated timer
// - Sense select plus source clear clocks byte timer
// - Source field 11 clocks gated timer
// - Gated timer off, free-running or gated
module cs_sense_counter #(
	parameter int PINS = 8,
	parameter int GW   = 16
) (
	input  wire logic            core_clk_i,
	input  wire logic            rst_n_i,
	input  wire logic [7:0]      addr_i,
	input  wire logic [7:0]      wdata_i,
	input  wire logic            wr_i,
	input  wire logic            rd_i,
	output logic      [7:0]      rdata_o,
	input  wire logic            sense_osc_i,
	input  wire logic            gate_i,
	output logic      [PINS-1:0] cap_sense_pin_o,
	output logic                 osc_enable_o,
	output logic      [1:0]      osc_current_range_o
);
	// Refuse sizes that the fixed channel field and byte lanes cannot serve
	if (PINS != 8 || GW != 16) begin : g_bad_size
		$error("cs_sense_counter: PINS must be 8 and GW 16");
	end

	// Control state
	logic                           enable_q, enable_d;
	logic                           sense_byte_q, sense_byte_d;
	logic [cs_pkg::RANGE_W-1:0]     range_q, range_d;
	logic [cs_pkg::CHAN_W-1:0]      chan_q, chan_d;
	logic                           byte_cs_q, byte_cs_d;
	logic                           g_on_q, g_on_d;
	logic                           g_ge_q, g_ge_d;
	logic [cs_pkg::SRC_W-1:0]       g_src_q, g_src_d;
	// Timer state
	logic [7:0]                     byte_cnt_q, byte_cnt_d;
	logic [GW-1:0]                  gated_cnt_q, gated_cnt_d;
	logic [7:0]                     rdata_q, rdata_d;
	// Synchronised inputs
	logic                           osc_level;
	logic                           osc_rise;
	logic                           gate_level;
	logic                           byte_tick;
	logic                           gated_tick;
	logic                           gated_run;

	// Register match helper
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	// Oscillator edges brought into core clock domain
	cs_edge_sync u_osc_sync (
		.core_clk_i (core_clk_i),
		.rst_n_i    (rst_n_i),
		.async_i    (sense_osc_i),
		.level_o    (osc_level),
		.rise_o     (osc_rise)
	);

	// Gate pin synchroniser
	cs_edge_sync u_gate_sync (
		.core_clk_i (core_clk_i),
		.rst_n_i    (rst_n_i),
		.async_i    (gate_i),
		.level_o    (gate_level),
		.rise_o     ()
	);

	// Analog mux steering: one-hot pin enable while module is on
	always_comb begin
		cap_sense_pin_o = '0;
		if (enable_q) begin
			cap_sense_pin_o[chan_q] = 1'b1;
		end
	end
	assign osc_enable_o        = enable_q;
	assign osc_current_range_o = range_q;

	// Timer clock selection
	assign byte_tick  = sense_byte_q & ~byte_cs_q & osc_rise;
	assign gated_run  = g_on_q & (~g_ge_q | gate_level);
	always_comb begin
		case (cs_pkg::cs_src_e'(g_src_q))
			cs_pkg::CS_SRC_CORE:  gated_tick = gated_run;
			cs_pkg::CS_SRC_SENSE: gated_tick = gated_run & osc_rise;
			default:              gated_tick = 1'b0;
		endcase
	end

	// Control register writes
	always_comb begin
		enable_d     = enable_q;
		sense_byte_d = sense_byte_q;
		range_d      = range_q;
		chan_d       = chan_q;
		byte_cs_d    = byte_cs_q;
		g_on_d       = g_on_q;
		g_ge_d       = g_ge_q;
		g_src_d      = g_src_q;
		if (wr_i) begin
			if (hit(addr_i, cs_pkg::ADDR_SENSE_CTRL_FIRST)) begin
				enable_d     = wdata_i[cs_pkg::FIRST_ENABLE_BIT];
				sense_byte_d = wdata_i[cs_pkg::FIRST_SENSE_BYTE_BIT];
				range_d      = wdata_i[cs_pkg::FIRST_RANGE_LSB +: cs_pkg::RANGE_W];
			end else if (hit(addr_i, cs_pkg::ADDR_SENSE_CTRL_SECOND)) begin
				chan_d = wdata_i[cs_pkg::CHAN_W-1:0];
			end else if (hit(addr_i, cs_pkg::ADDR_BYTE_TIMER_CFG)) begin
				byte_cs_d = wdata_i[cs_pkg::BYTE_CS_BIT];
			end else if (hit(addr_i, cs_pkg::ADDR_GATED_TIMER_CTRL)) begin
				g_on_d  = wdata_i[cs_pkg::GATED_ON_BIT];
				g_ge_d  = wdata_i[cs_pkg::GATED_GE_BIT];
				g_src_d = wdata_i[cs_pkg::GATED_SRC_LSB +: cs_pkg::SRC_W];
			end
		end
	end

	// Control registers
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			enable_q     <= 1'b0;
			sense_byte_q <= 1'b0;
			range_q      <= '0;
			chan_q       <= '0;
			byte_cs_q    <= cs_pkg::RST_BYTE_CS;
			g_on_q       <= 1'b0;
			g_ge_q       <= 1'b0;
			g_src_q      <= '0;
		end else begin
			enable_q     <= enable_d;
			sense_byte_q <= sense_byte_d;
			range_q      <= range_d;
			chan_q       <= chan_d;
			byte_cs_q    <= byte_cs_d;
			g_on_q       <= g_on_d;
			g_ge_q       <= g_ge_d;
			g_src_q      <= g_src_d;
		end
	end

	// Counters: software write loads, otherwise count ticks
	always_comb begin
		byte_cnt_d  = byte_cnt_q;
		gated_cnt_d = gated_cnt_q;
		if (wr_i && hit(addr_i, cs_pkg::ADDR_BYTE_TIMER_COUNT)) begin
			byte_cnt_d = wdata_i;
		end else if (byte_tick) begin
			byte_cnt_d = byte_cnt_q + 8'h01;
		end
		if (wr_i && hit(addr_i, cs_pkg::ADDR_GATED_COUNT_LOW)) begin
			gated_cnt_d = {gated_cnt_q[GW-1:8], wdata_i};
		end else if (wr_i && hit(addr_i, cs_pkg::ADDR_GATED_COUNT_HIGH)) begin
			gated_cnt_d = {wdata_i, gated_cnt_q[7:0]};
		end else if (gated_tick) begin
			gated_cnt_d = gated_cnt_q + {{(GW-1){1'b0}}, 1'b1};
		end
	end

	// Counter registers
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			byte_cnt_q  <= cs_pkg::RST_BYTE;
			gated_cnt_q <= '0;
		end else begin
			byte_cnt_q  <= byte_cnt_d;
			gated_cnt_q <= gated_cnt_d;
		end
	end

	// Read decode, data one cycle after the strobe
	always_comb begin
		rdata_d = 8'h00;
		if (rd_i) begin
			if (hit(addr_i, cs_pkg::ADDR_SENSE_CTRL_FIRST)) begin
				rdata_d[cs_pkg::FIRST_ENABLE_BIT]                      = enable_q;
				rdata_d[cs_pkg::FIRST_SENSE_BYTE_BIT]                  = sense_byte_q;
				rdata_d[cs_pkg::FIRST_RANGE_LSB +: cs_pkg::RANGE_W]    = range_q;
				rdata_d[cs_pkg::FIRST_PHASE_BIT]                       = osc_level;
			end else if (hit(addr_i, cs_pkg::ADDR_SENSE_CTRL_SECOND)) begin
				rdata_d[cs_pkg::CHAN_W-1:0] = chan_q;
			end else if (hit(addr_i, cs_pkg::ADDR_BYTE_TIMER_CFG)) begin
				rdata_d[cs_pkg::BYTE_CS_BIT] = byte_cs_q;
			end else if (hit(addr_i, cs_pkg::ADDR_BYTE_TIMER_COUNT)) begin
				rdata_d = byte_cnt_q;
			end else if (hit(addr_i, cs_pkg::ADDR_GATED_TIMER_CTRL)) begin
				rdata_d[cs_pkg::GATED_ON_BIT]                    = g_on_q;
				rdata_d[cs_pkg::GATED_GE_BIT]                    = g_ge_q;
				rdata_d[cs_pkg::GATED_SRC_LSB +: cs_pkg::SRC_W]  = g_src_q;
			end else if (hit(addr_i, cs_pkg::ADDR_GATED_COUNT_LOW)) begin
				rdata_d = gated_cnt_q[7:0];
			end else if (hit(addr_i, cs_pkg::ADDR_GATED_COUNT_HIGH)) begin
				rdata_d = gated_cnt_q[GW-1:8];
			end
		end
	end

	// Read data register
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= rdata_d;
		end
	end
	assign rdata_o = rdata_q;
endmodule
`default_nettype wire

// ### logic/cs_pkg.sv
// Constants for the capacitive sense frequency counter
package cs_pkg;
	// Register byte offsets
	localparam logic [7:0] ADDR_SENSE_CTRL_FIRST  = 8'h00;
	localparam logic [7:0] ADDR_SENSE_CTRL_SECOND = 8'h04;
	localparam logic [7:0] ADDR_BYTE_TIMER_CFG    = 8'h08;
	localparam logic [7:0] ADDR_BYTE_TIMER_COUNT  = 8'h0C;
	localparam logic [7:0] ADDR_GATED_TIMER_CTRL  = 8'h10;
	localparam logic [7:0] ADDR_GATED_COUNT_LOW   = 8'h14;
	localparam logic [7:0] ADDR_GATED_COUNT_HIGH  = 8'h18;

	// Field positions in sense_ctrl_first
	localparam int FIRST_ENABLE_BIT      = 7;
	localparam int FIRST_SENSE_BYTE_BIT  = 5;
	localparam int FIRST_RANGE_LSB       = 2;
	localparam int FIRST_PHASE_BIT       = 1;
	localparam int RANGE_W               = 2;
	// Field positions in the remaining registers
	localparam int CHAN_W                = 3;
	localparam int BYTE_CS_BIT           = 0;
	localparam int GATED_ON_BIT          = 0;
	localparam int GATED_GE_BIT          = 2;
	localparam int GATED_SRC_LSB         = 6;
	localparam int SRC_W                 = 2;

	// Reset values
	localparam logic       RST_BYTE_CS   = 1'b1;
	localparam logic [7:0] RST_BYTE      = 8'h00;

	// Gated timer clock source choices
	typedef enum logic [1:0] {
		CS_SRC_CORE  = 2'b00,
		CS_SRC_NONE1 = 2'b01,
		CS_SRC_NONE2 = 2'b10,
		CS_SRC_SENSE = 2'b11
	} cs_src_e;
endpackage

// ### logic/cs_edge_sync.sv
// Two-flop synchroniser with rising edge detector
`timescale 1ns/100ps
`default_nettype none
module cs_edge_sync (
	input  wire logic core_clk_i,
	input  wire logic rst_n_i,
	input  wire logic async_i,
	output logic      level_o,
	output logic      rise_o
);
	logic meta_q;
	logic sync_q;
	logic last_q;
	logic meta_d;
	logic sync_d;
	logic last_d;

	// Next values: first stage read only by second
	always_comb begin
		meta_d = async_i;
		sync_d = meta_q;
		last_d = sync_q;
	end

	// Synchroniser and history flops
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			last_q <= 1'b0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
			last_q <= last_d;
		end
	end

	assign level_o = sync_q;
	assign rise_o  = sync_q & ~last_q;
endmodule
`default_nettype wire

// ### testbench/cs_sense_props.sv
// Port-level checks for the sense counter
`timescale 1ns/100ps
`default_nettype none
module cs_sense_props #(parameter int PINS = 8) (
	input wire logic            core_clk_i,
	input wire logic            rst_n_i,
	input wire logic [7:0]      addr_i,
	input wire logic [7:0]      wdata_i,
	input wire logic            wr_i,
	input wire logic            rd_i,
	input wire logic [7:0]      rdata_o,
	input wire logic            sense_osc_i,
	input wire logic            gate_i,
	input wire logic [PINS-1:0] cap_sense_pin_o,
	input wire logic            osc_enable_o,
	input wire logic [1:0]      osc_current_range_o
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	// Last write data and recent oscillator levels
	logic [7:0] wd_q;
	logic [3:0] osc_q;
	always_ff @(posedge core_clk_i) begin
		wd_q  <= wdata_i;
		osc_q <= {osc_q[2:0], sense_osc_i};
	end
	wire logic wr0 = wr_i && addr_i == 8'h00;
	wire logic rd0 = rd_i && addr_i == 8'h00;
	pin_onehot_a: assert property (osc_enable_o |-> $onehot(cap_sense_pin_o))
		else $error("pin select not one-hot");
	pin_off_a: assert property (!osc_enable_o |-> cap_sense_pin_o == '0)
		else $error("pin driven while disabled");
	chan_move_a: assert property (osc_enable_o && wr_i && addr_i == 8'h04 |=> cap_sense_pin_o == PINS'(1) << wd_q[2:0])
		else $error("pin did not follow channel");
	enable_set_a: assert property (wr0 |=> osc_enable_o == wd_q[7])
		else $error("enable not taken");
	range_set_a: assert property (wr0 |=> osc_current_range_o == wd_q[3:2])
		else $error("range not taken");
	range_read_a: assert property (rd0 |=> rdata_o[3:2] == osc_current_range_o && rdata_o[7] == osc_enable_o)
		else $error("first register readback wrong");
	phase_read_a: assert property (rd0 && (osc_q == 4'h0 || osc_q == 4'hF) |=> rdata_o[1] == osc_q[2])
		else $error("phase status wrong");
	idle_read_a: assert property (!rd_i |=> rdata_o == 8'h00)
		else $error("read data outside read slot");
	cover property (rd0 ##1 rdata_o[1]);
	cover property (wr_i && addr_i == 8'h10 && wdata_i == 8'hC5);
	cover property (osc_enable_o && cap_sense_pin_o[7]);
endmodule
`default_nettype wire

// ### testbench/cs_pad_model.sv
// Sense pad oscillator model
`timescale 1ns/100ps
`default_nettype none
module cs_pad_model (
	input  wire logic [7:0] pin_en_i,
	input  wire logic       osc_en_i,
	output logic            osc_o
);
	initial osc_o = 1'b0;
	// Pulses only on one powered pin, else the oscillator stalls low
	task automatic burst(input int n, input int half);
		for (int k = 0; k < n; k++) begin
			#(half) osc_o = osc_en_i && $onehot(pin_en_i);
			#(half) osc_o = 1'b0;
		end
	endtask
	// Static level for status reads
	task automatic hold(input logic lvl);
		osc_o = lvl;
	endtask
endmodule
`default_nettype wire

// ### testbench/cs_bench.sv
// Self-checking bench for the sense counter
`timescale 1ns/100ps
`default_nettype none
module cap_sense_frequency_counter_bench;
	logic       core_clk_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, gate_i = 1'b0;
	logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o, cap_sense_pin_o;
	logic       sense_osc_i, osc_enable_o;
	logic [1:0] osc_current_range_o;
	int         bad_count = 0, n_compared = 0, cyc = 0;
	always #2 core_clk_i = ~core_clk_i;
	cs_sense_counter uut (
		.core_clk_i          (core_clk_i),
		.rst_n_i             (rst_n_i),
		.addr_i              (addr_i),
		.wdata_i             (wdata_i),
		.wr_i                (wr_i),
		.rd_i                (rd_i),
		.rdata_o             (rdata_o),
		.sense_osc_i         (sense_osc_i),
		.gate_i              (gate_i),
		.cap_sense_pin_o     (cap_sense_pin_o),
		.osc_enable_o        (osc_enable_o),
		.osc_current_range_o (osc_current_range_o)
	);
	cs_pad_model pad (.pin_en_i(cap_sense_pin_o), .osc_en_i(osc_enable_o), .osc_o(sense_osc_i));
	// Bus cycles and comparison
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk_i);
		{addr_i, wdata_i, wr_i} <= {a, d, 1'b1};
		@(posedge core_clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
			bad_count++;
		end
	endtask
	task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] e);
		@(posedge core_clk_i);
		{addr_i, rd_i} <= {a, 1'b1};
		@(posedge core_clk_i);
		rd_i <= 1'b0;
		@(negedge core_clk_i);
		chk(nm, e, rdata_o);
	endtask
	// Byte timer config reset value, unmapped read, channel and range fields
	task automatic t_setup;
		rd("byte cfg", 8'h08, 8'h01);
		rd("unmapped", 8'h1C, 8'h00);
		for (int r = 0; r < 4; r++) begin
			wr(8'h00, 8'h80 | 8'(r << 2));
			@(negedge core_clk_i);
			chk("range", 8'(r), {6'h00, osc_current_range_o});
		end
		for (int c = 0; c < 8; c++) begin
			wr(8'h04, 8'(c));
			@(negedge core_clk_i);
			chk("pin", 8'h01 << c, cap_sense_pin_o);
		end
		$display("t_setup done");
	endtask
	// Byte timer counts sense edges only when selected
	task automatic t_byte;
		wr(8'h00, 8'hA0);
		wr(8'h08, 8'h00);
		wr(8'h0C, 8'h00);
		pad.burst(5, 10);
		rd("byte count", 8'h0C, 8'h05);
		wr(8'h08, 8'h01);
		pad.burst(3, 10);
		rd("byte held", 8'h0C, 8'h05);
		wr(8'h08, 8'h00);
		wr(8'h00, 8'h80);
		pad.burst(3, 10);
		rd("byte no sense", 8'h0C, 8'h05);
		$display("t_byte done");
	endtask
	// Gated timer enable table and clock sources
	task automatic t_gated;
		logic [7:0] ctl [7] = '{8'hC1, 8'hC0, 8'hC4, 8'hC5, 8'hC5, 8'h41, 8'h81};
		logic       g [7] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
		int         n [7] = '{4, 0, 0, 0, 4, 0, 0};
		int         tot = 0;
		wr(8'h00, 8'h80);
		wr(8'h14, 8'h00);
		wr(8'h18, 8'h00);
		for (int i = 0; i < 7; i++) begin
			@(posedge core_clk_i);
			gate_i <= g[i];
			wr(8'h10, ctl[i]);
			pad.burst(4, 10);
			repeat (4) @(posedge core_clk_i);
			wr(8'h10, 8'h00);
			tot += n[i];
			rd("gated low", 8'h14, 8'(tot));
		end
		rd("gated high", 8'h18, 8'h00);
		$display("t_gated done");
	endtask
	// Core clock source counts every cycle of a bus-timed window
	task automatic t_core;
		wr(8'h14, 8'h00);
		wr(8'h18, 8'h00);
		wr(8'h10, 8'h01);
		repeat (10) @(posedge core_clk_i);
		wr(8'h10, 8'h00);
		rd("core count", 8'h14, 8'h0C);
		$display("t_core done");
	endtask
	// Phase status follows the oscillator and ignores writes
	task automatic t_phase;
		pad.hold(1'b1);
		repeat (6) @(posedge core_clk_i);
		rd("phase high", 8'h00, 8'h82);
		wr(8'h00, 8'h82);
		pad.hold(1'b0);
		repeat (6) @(posedge core_clk_i);
		rd("phase low", 8'h00, 8'h80);
		wr(8'h00, 8'h00);
		@(negedge core_clk_i);
		chk("pins off", 8'h00, cap_sense_pin_o);
		$display("t_phase done");
	endtask
	task automatic tally_and_finish;
		$display("compared %0d mismatched %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// Hang guard
	always @(posedge core_clk_i) begin
		cyc++;
		if (cyc == 5000) begin
			bad_count++;
			tally_and_finish();
		end
	end
	initial begin
		repeat (3) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		t_setup();
		t_byte();
		t_gated();
		t_core();
		t_phase();
		tally_and_finish();
	end
endmodule
bind cs_sense_counter cs_sense_props #(.PINS(PINS)) props_i (
	.core_clk_i          (core_clk_i),
	.rst_n_i             (rst_n_i),
	.addr_i              (addr_i),
	.wdata_i             (wdata_i),
	.wr_i                (wr_i),
	.rd_i                (rd_i),
	.rdata_o             (rdata_o),
	.sense_osc_i         (sense_osc_i),
	.gate_i              (gate_i),
	.cap_sense_pin_o     (cap_sense_pin_o),
	.osc_enable_o        (osc_enable_o),
	.osc_current_range_o (osc_current_range_o)
);
`default_nettype wire
